// file: verilog/svrw_top.sv
// Purpose: supervisor reset pulse generator with watchdog and push-button
// Assumes: inputs synchronous except button and strobe; Avalon-MM slave
// Notes: power-on reset starts a full reset active time
// Functional notes
// - button low 40 ms starts reset
// - hold reset 250 ms after button release
// - margin select picks undervoltage trip level
// - delay select sets 150/600/1200 ms timeout
// - reset during undervoltage, then 250 ms
// - watchdog expiry gives 250 ms pulses, repeating
// - high reset output complements low one
// - strobe falling edge restarts watchdog
// - watchdog restarts on reset release
// - watchdog disabled during undervoltage
`timescale 1ns/100ps
module svrw_top import svrw_pkg::*; #(
	parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic pushbutton_reset_n_i,
	input wire logic watchdog_kick_n_i,
	input wire logic supply_margin_select_i,
	input wire logic [1:0] timeout_delay_select_i,
	input wire logic undervolt_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic margin_select_o,
	output logic reset_o,
	output logic reset_n_o
);
	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		svrw_state_t st;
		logic rst_act;
		logic rst_n;
		logic [10:0] cnt;
		logic [10:0] pb_cnt;
		logic [10:0] wd;
		logic pb_m;
		logic pb_s;
		logic kick_m;
		logic kick_s;
		logic kick_d;
		logic uv;
		logic margin;
		logic [1:0] td;
		svrw_evt_t status;
		svrw_evt_t mask;
		logic irq;
		logic wait_n;
		logic [31:0] rdata;
	} svrw_st_t;

	svrw_st_t s;
	svrw_st_t next_s;
	svrw_avs_req_t req;
	logic tick;
	logic kick_fall;
	logic pb_qual;
	logic wd_expire;
	logic sw_kick;
	logic sw_force;
	logic ack;
	svrw_evt_t evt;

	assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
		writedata: avs_writedata_i};

	svrw_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		next_s = s;
		evt = '0;
		// two-flop synchronisers, edges from second stage on
		next_s.pb_m = pushbutton_reset_n_i;
		next_s.pb_s = s.pb_m;
		next_s.kick_m = watchdog_kick_n_i;
		next_s.kick_s = s.kick_m;
		next_s.kick_d = s.kick_s;
		next_s.uv = undervolt_i;
		next_s.margin = supply_margin_select_i;
		next_s.td = timeout_delay_select_i;
		ack = (req.read || req.write) && s.wait_n;
		sw_kick = ack && req.write && req.address == REG_CTRL && req.writedata[CTRL_KICK];
		sw_force = ack && req.write && req.address == REG_CTRL && req.writedata[CTRL_FORCE];
		kick_fall = s.kick_d && !s.kick_s;
		// debounce: count ticks while held low
		if (s.pb_s) begin
			next_s.pb_cnt = '0;
		end else if (tick && s.pb_cnt != PB_TICKS) begin
			next_s.pb_cnt = s.pb_cnt + 11'h1;
		end
		pb_qual = s.pb_cnt == PB_TICKS;
		wd_expire = tick && s.wd >= tmo_ticks(s.td) - 11'h1;
		// watchdog timer
		if (s.uv || s.st != ST_IDLE || kick_fall || sw_kick) begin
			next_s.wd = '0;
		end else if (tick) begin
			next_s.wd = s.wd + 11'h1;
		end
		// reset pulse generator
		unique case (s.st)
			ST_IDLE: begin
				if (s.uv) begin
					next_s.st = ST_UV;
					evt.uv = 1'b1;
				end else if (pb_qual) begin
					next_s.st = ST_PB;
					evt.pb = 1'b1;
				end else if (wd_expire || sw_force) begin
					next_s.st = ST_HOLD;
					next_s.cnt = '0;
					evt.wd = wd_expire;
				end
			end
			ST_UV: begin
				if (!s.uv) begin
					next_s.st = ST_HOLD;
					next_s.cnt = '0;
				end
			end
			ST_PB: begin
				if (s.uv) begin
					next_s.st = ST_UV;
					evt.uv = 1'b1;
				end else if (s.pb_s) begin
					next_s.st = ST_HOLD;
					next_s.cnt = '0;
				end
			end
			ST_HOLD: begin
				if (s.uv) begin
					next_s.st = ST_UV;
					evt.uv = 1'b1;
				end else if (pb_qual) begin
					next_s.st = ST_PB;
					evt.pb = 1'b1;
				end else if (tick) begin
					if (s.cnt == HOLD_TICKS - 11'h1) begin
						next_s.st = ST_IDLE;
						evt.rel = 1'b1;
					end else begin
						next_s.cnt = s.cnt + 11'h1;
					end
				end
			end
		endcase
		next_s.rst_act = next_s.st != ST_IDLE;
		next_s.rst_n = next_s.st == ST_IDLE;
		// bus slave: one wait cycle, then acknowledge
		next_s.wait_n = (req.read || req.write) && !s.wait_n;
		next_s.rdata = '0;
		if (req.read && !s.wait_n) begin
			unique case (req.address)
				REG_STATUS: next_s.rdata = 32'(s.status);
				REG_MASK: next_s.rdata = 32'(s.mask);
				REG_STATE: begin
					next_s.rdata[STATE_RST] = s.rst_act;
					next_s.rdata[STATE_UV] = s.uv;
					next_s.rdata[STATE_TD +: 2] = s.td;
					next_s.rdata[STATE_MARGIN] = s.margin;
				end
				default: next_s.rdata = '0;
			endcase
		end
		if (ack && req.write && req.address == REG_MASK) begin
			next_s.mask = svrw_evt_t'(req.writedata[3:0]);
		end
		// read clears status, new event wins
		if (ack && req.read && req.address == REG_STATUS) begin
			next_s.status = evt;
		end else begin
			next_s.status = s.status | evt;
		end
		next_s.irq = |(next_s.status & next_s.mask);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '{st: ST_HOLD, rst_act: 1'b1, rst_n: 1'b0, pb_m: 1'b1, pb_s: 1'b1,
				kick_m: 1'b1, kick_s: 1'b1, kick_d: 1'b1, mask: MASK_RESET, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign reset_o = s.rst_act;
	assign reset_n_o = s.rst_n;
	assign margin_select_o = s.margin;
	assign irq_o = s.irq;
	assign avs_waitrequest_o = !s.wait_n;
	assign avs_readdata_o = s.rdata;

	// ********************************************************
	// assertions
	// ********************************************************
	sequence hold_done_s;
		s.st == ST_HOLD && tick && s.cnt == HOLD_TICKS - 11'h1 && !s.uv && !pb_qual;
	endsequence
	sequence kick_fall_s;
		s.kick_d && !s.kick_s;
	endsequence
	sequence bus_req_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence

	out_compl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		reset_o == !reset_n_o) else $error("reset outputs not complementary");
	uv_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.uv |=> reset_o && !reset_n_o) else $error("undervoltage did not assert reset");
	hold_min_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(s.rst_act) |-> $past(s.st) == ST_HOLD && $past(s.cnt) == HOLD_TICKS - 11'h1)
		else $error("reset released before full active time");
	release_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hold_done_s |=> !reset_o ##0 s.status.rel) else $error("reset not released on time");
	wd_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(s.rst_act) |-> s.wd == 11'h0 ##1 s.wd <= 11'h1) else $error("watchdog not restarted");
	kick_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		kick_fall_s |=> s.wd == 11'h0) else $error("strobe edge did not clear watchdog");
	uv_wd_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.uv |=> s.wd == 11'h0) else $error("watchdog ran in undervoltage");
	pb_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_IDLE && !s.uv && pb_qual |=> s.st == ST_PB ##0 reset_o)
		else $error("qualified button did not start reset");
	wd_fire_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_IDLE && !s.uv && !pb_qual && tick && s.wd == tmo_ticks(s.td) - 11'h1
		|=> reset_o ##0 s.status.wd) else $error("watchdog expiry missed");
	bus_ack_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		bus_req_s |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle late");
	irq_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_o == |(s.status & s.mask)) else $error("interrupt level mismatch");

	// ********************************************************
	// sequencer steps
	// ********************************************************
	sequence uv_gone_s;
		s.st == ST_UV && !s.uv;
	endsequence
	sequence hold_wait_s;
		s.st == ST_HOLD && !s.uv && !pb_qual && !tick;
	endsequence
	uv_exit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		uv_gone_s |=> s.st == ST_HOLD && s.cnt == 11'h0 && reset_o)
		else $error("supply recovery did not start hold");
	hold_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hold_wait_s |=> s.st == ST_HOLD && $stable(s.cnt))
		else $error("hold count moved without tick");
	pb_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_PB && !s.uv && !s.pb_s |=> s.st == ST_PB && reset_o)
		else $error("reset left while button held");
	idle_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_IDLE && !s.uv && !pb_qual && !wd_expire && !sw_force |=> !reset_o)
		else $error("reset without cause");
	wd_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st != ST_IDLE |=> s.wd == 11'h0)
		else $error("watchdog ran during reset");
	wd_steady_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_IDLE && !s.uv && !kick_fall && !sw_kick && !tick |=> $stable(s.wd))
		else $error("watchdog moved on steady strobe");
	pb_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.pb_s |=> s.pb_cnt == 11'h0)
		else $error("debounce count kept after release");
	pb_limit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.pb_cnt <= PB_TICKS)
		else $error("debounce count overran");
	margin_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> margin_select_o == $past(supply_margin_select_i))
		else $error("margin select not forwarded");
	td_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> s.td == $past(timeout_delay_select_i))
		else $error("delay select not sampled");
	status_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ack && req.read && req.address == REG_STATUS && evt == '0 |=> s.status == '0)
		else $error("status read did not clear");
	wd_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		evt.wd |=> s.status.wd)
		else $error("watchdog event not recorded");
	sw_force_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_force && s.st == ST_IDLE && !s.uv && !pb_qual |=> s.st == ST_HOLD && reset_o)
		else $error("forced reset not started");
endmodule : svrw_top

// file: verilog/svrw_pkg.sv
// Purpose: shared constants and types of the reset supervisor
// Assumes: 250 MHz reference clock
// Notes: all interval counts are in millisecond ticks
package svrw_pkg;
	// ********************************************************
	// timing
	// ********************************************************
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned PB_MIN_MS = 40;
	localparam int unsigned RST_ACTIVE_MS = 250;
	localparam int unsigned WD_SHORT_MS = 150;
	localparam int unsigned WD_MID_MS = 600;
	localparam int unsigned WD_LONG_MS = 1200;
	localparam int unsigned CNT_W = 11;
	// one extra tick covers the partial first tick
	localparam logic [10:0] PB_TICKS = 11'(PB_MIN_MS + 1);
	localparam logic [10:0] HOLD_TICKS = 11'(RST_ACTIVE_MS + 1);
	// ********************************************************
	// supply margin
	// ********************************************************
	localparam int unsigned TRIP_5PCT_MV = 4620;
	localparam int unsigned TRIP_10PCT_MV = 4370;
	localparam logic MARGIN_5PCT = 1'b0;
	localparam logic MARGIN_10PCT = 1'b1;
	// ********************************************************
	// registers
	// ********************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	localparam logic [3:0] REG_STATE = 4'hc;
	localparam int unsigned CTRL_KICK = 0;
	localparam int unsigned CTRL_FORCE = 1;
	localparam int unsigned STATE_RST = 0;
	localparam int unsigned STATE_UV = 1;
	localparam int unsigned STATE_TD = 2;
	localparam int unsigned STATE_MARGIN = 4;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {TD_LOW, TD_FLOAT, TD_HIGH} svrw_td_t;
	typedef enum logic [1:0] {ST_IDLE, ST_UV, ST_PB, ST_HOLD} svrw_state_t;
	typedef struct packed {
		logic rel;
		logic pb;
		logic wd;
		logic uv;
	} svrw_evt_t;
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} svrw_avs_req_t;

	function automatic logic [10:0] tmo_ticks(input logic [1:0] sel);
		case (sel)
			TD_LOW: tmo_ticks = 11'(WD_SHORT_MS);
			TD_FLOAT: tmo_ticks = 11'(WD_MID_MS);
			default: tmo_ticks = 11'(WD_LONG_MS);
		endcase
	endfunction : tmo_ticks
endpackage : svrw_pkg

// file: verilog/svrw_tick.sv
// Purpose: millisecond tick prescaler
// Assumes: CYCLES reference clocks per tick
// Notes: tick_o is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
module svrw_tick import svrw_pkg::*; #(
	parameter int unsigned CYCLES = MS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	output logic tick_o
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} svrw_tick_st_t;

	svrw_tick_st_t s;
	svrw_tick_st_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt >= 32'(CYCLES - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 32'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

	tick_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.tick |-> s.cnt == 32'h0) else $error("tick not aligned to wrap");
endmodule : svrw_tick

// file: verification/svrw_host_model.sv
// Purpose: host strobe and push-button model
// Assumes: shares the reference clock
// Notes: button has a pull-up, so released reads high
`timescale 1ns/100ps
module svrw_host_model (
	input wire logic clk_i,
	input wire logic kick_en_i,
	input wire logic press_i,
	output logic kick_n_o = 1'b1,
	output logic button_n_o
);
	int cnt = 0;
	assign button_n_o = !press_i;
	always @(posedge clk_i) begin
		cnt <= kick_en_i ? cnt + 1 : 0;
		// two-cycle low strobe every 400 clocks
		kick_n_o <= !(kick_en_i && (cnt % 400) > 397);
	end
endmodule : svrw_host_model

// file: verification/testbench.sv
// Purpose: self-checking bench of the reset supervisor
// Assumes: short tick of four clocks
// Notes: all times counted in clocks
`timescale 1ns/100ps
module testbench import svrw_pkg::*;;
	localparam int T = 4;
	typedef struct {logic [1:0] td; int tmo;} svrw_row_t;
	svrw_row_t rows[4] = '{'{2'h0, 150}, '{2'h1, 600}, '{2'h2, 1200}, '{2'h3, 1200}};
	logic ref_clk = 0, rst = 1, margin = 0, uv = 0, rd = 0, wr = 0, kick_en = 0, press = 0;
	logic [1:0] td = 2'h0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic wait_o, irq, msel, reset, reset_n, kick_n, pb_n;
	int err_count = 0, samples_checked = 0, n;
	always #2 ref_clk = ~ref_clk;
	svrw_top #(.TICK_CYCLES(T)) uut (.ref_clk_i(ref_clk), .rst_i(rst), .pushbutton_reset_n_i(pb_n),
		.watchdog_kick_n_i(kick_n), .supply_margin_select_i(margin), .timeout_delay_select_i(td),
		.undervolt_i(uv), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .irq_o(irq),
		.margin_select_o(msel), .reset_o(reset), .reset_n_o(reset_n));
	svrw_host_model host (.clk_i(ref_clk), .kick_en_i(kick_en), .press_i(press), .kick_n_o(kick_n),
		.button_n_o(pb_n));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task chk_rng(input string nm, input int lo, input int hi, input int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			err_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		do @(posedge ref_clk); while (wait_o !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task wait_rst(input logic lvl, input int lim);
		n = 0;
		while (reset !== lvl && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : wait_rst
	task summarize;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	always @(negedge ref_clk) begin
		if (!rst) chk("reset_n", 32'(!reset), 32'(reset_n));
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		summarize();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		wait_rst(0, 2000);
		chk_rng("power-on hold", 250 * T, 252 * T + 4, n);
		foreach (rows[i]) begin
			wait_rst(1, 6000);
			chk_rng("timeout", rows[i].tmo * T - T, rows[i].tmo * T + T + 4, n);
			td <= rows[(i + 1) % 4].td;
			wait_rst(0, 2000);
			chk_rng("wd pulse", 250 * T, 252 * T + 4, n);
		end
		kick_en <= 1'b1;
		bus(0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(0, REG_MASK, 32'h0);
		chk("mask reset", 32'h0, q);
		bus(0, REG_STATUS, 32'h0);
		bus(0, REG_STATUS, 32'h0);
		chk("status cleared", 32'h0, q);
		margin <= 1'b1;
		bus(0, REG_STATE, 32'h0);
		chk("state margin", 32'h1, 32'(q[4]));
		chk("margin out", 32'h1, 32'(msel));
		bus(1, REG_MASK, 32'h2);
		wait_rst(1, 900 * T);
		chk("kicked", 32'h0, 32'(reset));
		kick_en <= 1'b0;
		wait_rst(1, 200 * T);
		chk_rng("steady strobe", 1, 200 * T - 1, n);
		repeat (4) @(posedge ref_clk);
		chk("irq set", 32'h1, 32'(irq));
		bus(0, REG_STATUS, 32'h0);
		chk("status wd", 32'h1, 32'(q[1]));
		repeat (3) @(posedge ref_clk);
		chk("irq clear", 32'h0, 32'(irq));
		wait_rst(0, 2000);
		uv <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("uv reset", 32'h1, 32'(reset));
		repeat (300 * T) @(posedge ref_clk);
		bus(0, REG_STATUS, 32'h0);
		chk("uv no wd", 32'h1, 32'(q[1:0]));
		uv <= 1'b0;
		wait_rst(0, 2000);
		chk_rng("uv hold", 250 * T, 252 * T + 4, n);
		press <= 1'b1;
		repeat (30 * T) @(posedge ref_clk);
		chk("short press", 32'h0, 32'(reset));
		press <= 1'b0;
		repeat (10) @(posedge ref_clk);
		press <= 1'b1;
		wait_rst(1, 60 * T);
		chk_rng("press", 40 * T, 42 * T + 4, n);
		repeat (20 * T) @(posedge ref_clk);
		press <= 1'b0;
		wait_rst(0, 300 * T);
		chk_rng("release hold", 250 * T, 252 * T + 4, n);
		bus(1, REG_CTRL, 32'h2);
		wait_rst(1, 10);
		chk("force", 32'h1, 32'(reset));
		wait_rst(0, 2000);
		chk_rng("force hold", 250 * T, 252 * T + 4, n);
		for (int k = 0; k < 8; k++) begin
			repeat (100 * T) @(posedge ref_clk);
			bus(1, REG_CTRL, 32'h1);
			chk("sw kick", 32'h0, 32'(reset));
		end
		summarize();
	end
endmodule : testbench
